// File: phy_cfg_map.svh
// register offsets, field positions, reset values and timing counts of the pin/line-driver/
// equalizer configuration bank; included by its bare name, definitions only
`ifndef PHY_CFG_MAP_SVH
`define PHY_CFG_MAP_SVH

// register indices; byte address is four times the index
`define IO_PIN_CONFIG_IDX 10'h302
`define SPARE_CONTROL_BITS_IDX 10'h308
`define LINE_DRIVER_LEVEL_CFG_A_IDX 10'h30B
`define LINE_DRIVER_LEVEL_CFG_B_IDX 10'h30C
`define EQUALIZER_ADAPT_CFG_A_IDX 10'h30F

// reset values
`define IO_PIN_CONFIG_RST 16'h0000
`define SPARE_CONTROL_BITS_RST 16'h0002
`define LINE_DRIVER_LEVEL_CFG_A_RST 16'h0C00
`define LINE_DRIVER_LEVEL_CFG_B_RST 16'h0020
`define EQUALIZER_ADAPT_CFG_A_RST 16'h0464

// writable bits of each register; other bits read as their reset value, spare bit 0 mirrors the aux disable
`define IO_PIN_CONFIG_WMASK 16'hC047
`define SPARE_CONTROL_BITS_WMASK 16'hFFFC
`define LINE_DRIVER_LEVEL_CFG_A_WMASK 16'h0FFF
`define LINE_DRIVER_LEVEL_CFG_B_WMASK 16'h003F
`define EQUALIZER_ADAPT_CFG_A_WMASK 16'h07FF

// field positions: io_pin_config
`define TERM_SEL_HI 15
`define TERM_SEL_LO 14
`define AUX_CLK_OFF_BIT 6
`define SHARED_SEL_HI 2
`define SHARED_SEL_LO 0
// field positions: spare_control_bits
`define AUX_OFF_STATUS_BIT 0
`define RMII_RX_CLK_SEL_BIT 2
`define FREEZE_ON_RXDIS_BIT 4
`define MSE_BYPASS_WAKE_BIT 5
`define STEADY_FREEZE_BIT 6
`define REFRESH_COUNT_EN_BIT 7
`define REFRESH_TIMER_SEL_BIT 8
`define WAIT_FREEZE_LO 10
// field positions: line driver levels
`define MINUS_CODE_HI 11
`define MINUS_CODE_LO 6
`define ZERO_CODE_HI 5
`define ZERO_CODE_LO 0
`define PLUS_CODE_HI 5
`define PLUS_CODE_LO 0
// field positions: equalizer_adapt_cfg_a
`define STAGE1_TIMER_HI 10
`define STAGE1_TIMER_LO 8
`define STAGE1_HOLD_BIT 7
`define STAGE2_HOLD_BIT 6
`define STAGE3_HOLD_BIT 5

// timing
`define CLK_FREQ_KHZ 20000
`define REFRESH_SHORT_US 176
`define REFRESH_LONG_US 192
`define REFRESH_SHORT_CYC ((`REFRESH_SHORT_US * `CLK_FREQ_KHZ + 999) / 1000)
`define REFRESH_LONG_CYC ((`REFRESH_LONG_US * `CLK_FREQ_KHZ + 999) / 1000)

`endif

// File: phy_cfg_pkg.sv
// types shared by the configuration bank and its surroundings
// assumes nothing beyond a SystemVerilog compiler
package phy_cfg_pkg;

  // receive sequencer state as seen by the bank
  typedef enum logic [2:0] {
    seq_other = 3'b000,
    adaptation_a = 3'b001,
    lowpower_wake_state = 3'b010,
    lowpower_freeze_state = 3'b011,
    lowpower_wait_state = 3'b100
  } seq_state_t;

  // three-level transmit symbol
  typedef enum logic [1:0] {
    sym_zero = 2'b00,
    sym_plus_one = 2'b01,
    sym_minus_one = 2'b10
  } tx_symbol_t;

  // equalizer stage currently running
  typedef enum logic [1:0] {
    stage_none = 2'b00,
    stage_ffe1 = 2'b01,
    stage_ffe2 = 2'b10,
    stage_ffe3 = 2'b11
  } eq_stage_t;

  // freeze commands toward the adaptation loops
  typedef struct packed {
    logic all_loops;
    logic mse_bypass;
    logic steady_hold;
    logic refresh_count;
    logic [5:0] wait_hold; // gain, ffe, dfe, prop, integral, dc removal
    logic ffe_stage;
  } freeze_ctrl_t;

endpackage

// File: phy_cfg_bank.sv
// configuration bank: pin termination and function muxing, low-power freeze steering,
// line-driver level codes and first equalizer options, reached as an APB slave
// assumes all pin sources, sequencer state and symbols come from logic on i_clk
//
// Overview of operation
// RULE_01: termination field drives MAC pin termination select
// RULE_02: aux disable picks 25 MHz clock or indicator
// RULE_03: software sets aux disable to save current
// RULE_04: three-bit selector picks shared pin function
// RULE_05: status bit mirrors aux clock disable, read-only
// RULE_06: spare bit 2 selects RMII receive clock
// RULE_07: bit 4 freezes loops while receiver disabled
// RULE_08: bit 5 skips MSE check in wake
// RULE_09: bit 6 freezes in steady before freeze state
// RULE_10: bit 7 counter freeze, bit 8 length
// RULE_11: bits 10-15 freeze functions in wait state
// RULE_12: minus-one symbol uses its code, reset 0x30
// RULE_13: zero symbol uses its code, reset zero
// RULE_14: plus-one symbol uses its code, reset 0x20
// RULE_15: stage one timer select field, reset 4
// RULE_16: stage one hold freezes equalizer coefficients
// RULE_17: stage two/three holds, both reset one
// RULE_18: reserved bits read zero, writes ignored
//
// Decided for this implementation: the APB slave port.
`include "phy_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_cfg_bank
  import phy_cfg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_aux_25mhz_clock_output,
  input wire logic i_second_indicator_gpio,
  input wire logic i_master_mode,
  input wire logic i_ref_clock_50mhz_output,
  input wire logic i_third_indicator_output,
  input wire logic i_wake_packet_indication,
  input wire logic i_management_interrupt_output,
  input wire logic i_receiver_disabled_flag,
  input wire seq_state_t i_seq_state,
  input wire logic i_freeze_entry_pending,
  input wire logic i_refresh_start,
  input wire tx_symbol_t i_tx_symbol,
  input wire eq_stage_t i_eq_stage,
  output logic [1:0] o_mac_pin_termination_sel,
  output logic o_aux_pin,
  output logic o_shared_pin,
  output logic o_rmii_rx_clk_sel,
  output freeze_ctrl_t o_freeze,
  output logic [5:0] o_line_driver_code,
  output logic [2:0] o_equalizer_stage1_timer_sel
);

  localparam int NREG = 5;
  localparam logic [11:0] CNT_SHORT = 12'(`REFRESH_SHORT_CYC);
  localparam logic [11:0] CNT_LONG = 12'(`REFRESH_LONG_CYC);
  localparam logic [9:0] IDX_TBL [NREG] = '{`IO_PIN_CONFIG_IDX, `SPARE_CONTROL_BITS_IDX,
    `LINE_DRIVER_LEVEL_CFG_A_IDX, `LINE_DRIVER_LEVEL_CFG_B_IDX, `EQUALIZER_ADAPT_CFG_A_IDX};
  localparam logic [15:0] RST_TBL [NREG] = '{`IO_PIN_CONFIG_RST, `SPARE_CONTROL_BITS_RST,
    `LINE_DRIVER_LEVEL_CFG_A_RST, `LINE_DRIVER_LEVEL_CFG_B_RST, `EQUALIZER_ADAPT_CFG_A_RST};
  localparam logic [15:0] MASK_TBL [NREG] = '{`IO_PIN_CONFIG_WMASK,
    `SPARE_CONTROL_BITS_WMASK, `LINE_DRIVER_LEVEL_CFG_A_WMASK,
    `LINE_DRIVER_LEVEL_CFG_B_WMASK, `EQUALIZER_ADAPT_CFG_A_WMASK};

  // the decode needs the full index range of the bank
  if (ADDR_W < 12) begin : g_bad_addr_w
    $error("ADDR_W must be at least 12");
  end

  logic [15:0] regs [NREG];
  logic [NREG-1:0] hit;
  logic [15:0] lane_mask;
  logic setup_phase;
  logic access_done;
  logic any_hit;
  logic [15:0] read_word;
  logic [15:0] spare_read;
  logic [15:0] io_pin_config;
  logic [15:0] spare_control_bits;
  logic [15:0] line_driver_level_cfg_a;
  logic [15:0] line_driver_level_cfg_b;
  logic [15:0] equalizer_adapt_cfg_a;
  logic [11:0] refresh_count;
  logic [11:0] next_refresh_count;
  logic [11:0] refresh_load;
  logic next_aux_pin;
  logic next_shared_pin;
  logic [5:0] next_line_code;
  logic next_ffe_hold;
  freeze_ctrl_t next_freeze;

  // apb phase decode; the write lands at the access edge with pready high
  assign setup_phase = i_psel & ~i_penable;
  assign access_done = i_psel & i_penable & o_pready;
  assign lane_mask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  assign any_hit = |hit;

  // one register per entry, with write mask and byte lanes
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    assign hit[g] = (i_paddr == ADDR_W'({IDX_TBL[g], 2'b00}));
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        regs[g] <= RST_TBL[g];
      end else if (access_done && i_pwrite && hit[g]) begin
        regs[g] <= (regs[g] & ~(MASK_TBL[g] & lane_mask)) |
                   (i_pwdata[15:0] & MASK_TBL[g] & lane_mask); // [RULE_18]
      end
    end
  end

  assign io_pin_config = regs[0];
  assign spare_control_bits = regs[1];
  assign line_driver_level_cfg_a = regs[2];
  assign line_driver_level_cfg_b = regs[3];
  assign equalizer_adapt_cfg_a = regs[4];

  // read mux; status bit mirrors the aux disable, constant bit 1 stays set
  assign spare_read = {spare_control_bits[15:1],
                       io_pin_config[`AUX_CLK_OFF_BIT]}; // [RULE_05]
  assign read_word = hit[0] ? io_pin_config :
                     hit[1] ? spare_read :
                     hit[2] ? line_driver_level_cfg_a :
                     hit[3] ? line_driver_level_cfg_b :
                     hit[4] ? equalizer_adapt_cfg_a : 16'h0000; // [RULE_18]

  // answer one cycle after setup; unmapped addresses give pslverr and zero data
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_phase;
      o_pslverr <= setup_phase & ~any_hit;
      if (setup_phase) begin
        o_prdata <= {16'h0000, read_word};
      end
    end
  end

  // shared pin muxes
  assign next_aux_pin = io_pin_config[`AUX_CLK_OFF_BIT] ? i_second_indicator_gpio :
                        i_aux_25mhz_clock_output; // [RULE_02]
  always_comb begin
    unique case (io_pin_config[`SHARED_SEL_HI:`SHARED_SEL_LO]) // [RULE_04]
      3'h0: next_shared_pin = i_master_mode & i_ref_clock_50mhz_output;
      3'h1: next_shared_pin = i_third_indicator_output;
      3'h2: next_shared_pin = i_wake_packet_indication;
      3'h4: next_shared_pin = i_management_interrupt_output;
      3'h6: next_shared_pin = 1'b1;
      3'h3, 3'h5, 3'h7: next_shared_pin = 1'b0;
    endcase
  end

  // line driver code for the current symbol
  always_comb begin
    unique case (i_tx_symbol)
      sym_minus_one: next_line_code =
        line_driver_level_cfg_a[`MINUS_CODE_HI:`MINUS_CODE_LO]; // [RULE_12]
      sym_plus_one: next_line_code =
        line_driver_level_cfg_b[`PLUS_CODE_HI:`PLUS_CODE_LO]; // [RULE_14]
      sym_zero: next_line_code =
        line_driver_level_cfg_a[`ZERO_CODE_HI:`ZERO_CODE_LO]; // [RULE_13]
      default: next_line_code = 6'h00; // code 2'b11 is illegal
    endcase
  end

  // per-stage equalizer hold
  always_comb begin
    unique case (i_eq_stage)
      stage_ffe1: next_ffe_hold = equalizer_adapt_cfg_a[`STAGE1_HOLD_BIT]; // [RULE_16]
      stage_ffe2: next_ffe_hold = equalizer_adapt_cfg_a[`STAGE2_HOLD_BIT]; // [RULE_17]
      stage_ffe3: next_ffe_hold = equalizer_adapt_cfg_a[`STAGE3_HOLD_BIT]; // [RULE_17]
      stage_none: next_ffe_hold = 1'b0;
    endcase
  end

  // refresh freeze counter; bit 8 set picks the longer timer
  assign refresh_load = spare_control_bits[`REFRESH_TIMER_SEL_BIT] ? CNT_LONG : CNT_SHORT;
  always_comb begin
    if (!spare_control_bits[`REFRESH_COUNT_EN_BIT]) begin
      next_refresh_count = 12'h000; // [RULE_10]
    end else if (i_refresh_start) begin
      next_refresh_count = refresh_load; // [RULE_10]
    end else if (refresh_count != 12'h000) begin
      next_refresh_count = refresh_count - 12'h001;
    end else begin
      next_refresh_count = 12'h000;
    end
  end

  // freeze commands from spare bits, sequencer state and the per-stage equalizer hold
  assign next_freeze.all_loops = spare_control_bits[`FREEZE_ON_RXDIS_BIT] &
                                 i_receiver_disabled_flag; // [RULE_07]
  assign next_freeze.mse_bypass = spare_control_bits[`MSE_BYPASS_WAKE_BIT] &
                                  (i_seq_state == lowpower_wake_state); // [RULE_08]
  assign next_freeze.steady_hold = spare_control_bits[`STEADY_FREEZE_BIT] &
                                   (i_seq_state == adaptation_a) &
                                   i_freeze_entry_pending; // [RULE_09]
  assign next_freeze.refresh_count = (next_refresh_count != 12'h000); // [RULE_10]
  assign next_freeze.wait_hold = spare_control_bits[`WAIT_FREEZE_LO+5:`WAIT_FREEZE_LO] &
                                 {6{i_seq_state == lowpower_wait_state}}; // [RULE_11]
  assign next_freeze.ffe_stage = next_ffe_hold;

  // registered outputs toward the pins and the analog/dsp side
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      refresh_count <= 12'h000;
      o_mac_pin_termination_sel <= 2'h0;
      o_aux_pin <= 1'b0;
      o_shared_pin <= 1'b0;
      o_rmii_rx_clk_sel <= 1'b0;
      o_freeze <= '0;
      o_line_driver_code <= 6'h00;
      o_equalizer_stage1_timer_sel <= 3'h4;
    end else begin
      refresh_count <= next_refresh_count;
      o_mac_pin_termination_sel <= io_pin_config[`TERM_SEL_HI:`TERM_SEL_LO]; // [RULE_01]
      o_aux_pin <= next_aux_pin;
      o_shared_pin <= next_shared_pin;
      o_rmii_rx_clk_sel <= spare_control_bits[`RMII_RX_CLK_SEL_BIT]; // [RULE_06]
      o_freeze <= next_freeze;
      o_line_driver_code <= next_line_code;
      o_equalizer_stage1_timer_sel <=
        equalizer_adapt_cfg_a[`STAGE1_TIMER_HI:`STAGE1_TIMER_LO]; // [RULE_15]
    end
  end

  // checks on the driven side
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence apb_setup_s;
    i_psel && !i_penable;
  endsequence
  sequence apb_answer_s;
    o_pready ##1 !o_pready || (i_psel && !i_penable);
  endsequence

  term_sel_a: assert property (##1 o_mac_pin_termination_sel == // [RULE_01]
    $past(io_pin_config[15:14])) else $error("termination select mismatch");
  aux_pin_mux_a: assert property (io_pin_config[6] |=> // [RULE_02]
    o_aux_pin == $past(i_second_indicator_gpio)) else $error("aux pin not gpio");
  shared_const_a: assert property ( // [RULE_04]
    (io_pin_config[2:0] == 3'h6) |=> o_shared_pin) else $error("shared pin not high");
  shared_low_a: assert property ( // [RULE_04]
    (io_pin_config[2:0] inside {3'h3, 3'h5, 3'h7}) |=> !o_shared_pin)
    else $error("shared pin not low");
  aux_status_a: assert property (apb_setup_s and hit[1] |=> // [RULE_05]
    o_prdata[0] == $past(io_pin_config[6]) && o_prdata[1]) else $error("status bit wrong");
  rxdis_freeze_a: assert property (spare_control_bits[4] && i_receiver_disabled_flag |=> // [RULE_07]
    o_freeze.all_loops) else $error("loops not frozen");
  wait_freeze_a: assert property (i_seq_state != lowpower_wait_state |=> // [RULE_11]
    o_freeze.wait_hold == 6'h00) else $error("wait freeze outside wait");
  refresh_hold_a: assert property (spare_control_bits[7] && i_refresh_start && // [RULE_10]
    !$past(i_refresh_start) ##1 spare_control_bits[7] [*8] |-> o_freeze.refresh_count)
    else $error("refresh freeze dropped");
  minus_code_a: assert property (i_tx_symbol == sym_minus_one |=> // [RULE_12]
    o_line_driver_code == $past(line_driver_level_cfg_a[11:6])) else $error("minus code");
  plus_code_a: assert property (i_tx_symbol == sym_plus_one |=> // [RULE_14]
    o_line_driver_code == $past(line_driver_level_cfg_b[5:0])) else $error("plus code");
  ffe_hold_a: assert property (i_eq_stage == stage_ffe1 |=> // [RULE_16]
    o_freeze.ffe_stage == $past(equalizer_adapt_cfg_a[7])) else $error("stage one hold");
  reserved_zero_a: assert property (apb_setup_s and hit[3] |=> // [RULE_18]
    o_prdata[31:6] == 26'h0) else $error("reserved bits not zero");
  apb_answer_a: assert property (apb_setup_s |=> apb_answer_s) // [RULE_18]
    else $error("apb answer timing");

endmodule

`default_nettype wire

// File: test_phy_cfg_bank.sv
// self-checking bench for the configuration bank: apb access, pin muxes, freeze
// steering, line-driver codes and equalizer options; the bench drives every input
`include "phy_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none

module test_phy_cfg_bank
  import phy_cfg_pkg::*;
;
  localparam logic [11:0] a_io = {`IO_PIN_CONFIG_IDX, 2'b00};
  localparam logic [11:0] a_sp = {`SPARE_CONTROL_BITS_IDX, 2'b00};
  localparam logic [11:0] a_la = {`LINE_DRIVER_LEVEL_CFG_A_IDX, 2'b00};
  localparam logic [11:0] a_lb = {`LINE_DRIVER_LEVEL_CFG_B_IDX, 2'b00};
  localparam logic [11:0] a_eq = {`EQUALIZER_ADAPT_CFG_A_IDX, 2'b00};
  logic i_clk, i_reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic aux25, gpio2, master, ref50, ind3, wake, mint, rxdis, pend, rstart;
  logic auxp, shp, rmii;
  logic [1:0] term;
  logic [5:0] code;
  logic [2:0] tsel;
  seq_state_t st;
  tx_symbol_t sym;
  eq_stage_t stg;
  freeze_ctrl_t frz;
  int err_count = 0;
  int total_checks = 0;

  phy_cfg_bank #(.ADDR_W(12)) uut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_aux_25mhz_clock_output(aux25), .i_second_indicator_gpio(gpio2),
    .i_master_mode(master), .i_ref_clock_50mhz_output(ref50),
    .i_third_indicator_output(ind3), .i_wake_packet_indication(wake),
    .i_management_interrupt_output(mint), .i_receiver_disabled_flag(rxdis),
    .i_seq_state(st), .i_freeze_entry_pending(pend), .i_refresh_start(rstart),
    .i_tx_symbol(sym), .i_eq_stage(stg), .o_mac_pin_termination_sel(term),
    .o_aux_pin(auxp), .o_shared_pin(shp), .o_rmii_rx_clk_sel(rmii), .o_freeze(frz),
    .o_line_driver_code(code), .o_equalizer_stage1_timer_sel(tsel)
  );

  // clock at 20 MHz
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; ready, read data and error are taken at the rising edge with ready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] v, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        wrap_up();
      end
      @(posedge i_clk);
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, s, v, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, v, e);
    check(v, x);
    check(32'(e), 32'h0);
  endtask

  // outputs follow their causes one cycle late; three edges leave margin
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  // reset contents, reset stage one timer select output, refusal of an unmapped word
  task automatic s_reset;
    logic [31:0] v;
    logic e;
    rdc(a_io, 32'h0000);
    rdc(a_sp, 32'h0002);
    rdc(a_la, 32'h0C00);
    rdc(a_lb, 32'h0020);
    rdc(a_eq, 32'h0464);
    apb(1'b0, 12'hC04, 32'h0, 4'h0, v, e);
    check(32'(e), 32'h1);
    check(v, 32'h0);
    check(32'(tsel), 32'h4);
  endtask

  // termination, byte lanes, aux pin source and its status mirror
  task automatic s_io;
    wr(a_io, 32'hFFFF_FFFF);
    rdc(a_io, 32'h0000_C047);
    wr(a_io, 32'h0000_4000);
    wr(a_io, 32'h0000_FFFF, 4'h1);
    rdc(a_io, 32'h0000_4047);
    check(32'(term), 32'h1);
    rdc(a_sp, 32'h0003);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(a_io, 32'h0);
      @(posedge i_clk);
      aux25 <= k[0];
      gpio2 <= !k[0];
      settle();
      check(32'(auxp), 32'(k[0] ^ (k < 2)));
    end
    rdc(a_sp, 32'h0002);
  endtask

  // every shared pin selection with one-hot sources, master mode on and off
  task automatic s_shared;
    logic [3:0] srcs;
    logic x;
    for (int sel = 0; sel < 8; sel++) begin
      wr(a_io, 32'(sel));
      for (int k = 0; k < 8; k++) begin
        srcs = 4'h1 << k[1:0];
        @(posedge i_clk);
        {mint, wake, ind3, ref50} <= srcs;
        master <= k[2];
        settle();
        case (sel)
          0: x = srcs[0] & k[2];
          1: x = srcs[1];
          2: x = srcs[2];
          4: x = srcs[3];
          6: x = 1'b1;
          default: x = 1'b0;
        endcase
        check(32'(shp), 32'(x));
      end
    end
  endtask

  // freeze steering across sequencer states; expected {all,mse,steady,refresh,wait,ffe}
  task automatic s_spare;
    seq_state_t ts [6] = '{seq_other, lowpower_wake_state, adaptation_a, adaptation_a,
                           lowpower_wait_state, lowpower_freeze_state};
    logic [1:0] tin [6] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b00, 2'b01};
    logic [10:0] fe [6] = '{11'h400, 11'h200, 11'h100, 11'h000, 11'h052, 11'h000};
    wr(a_sp, 32'h0000_A475);
    rdc(a_sp, 32'h0000_A476);
    check(32'(rmii), 32'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk);
      st <= ts[i];
      {rxdis, pend} <= tin[i];
      settle();
      check(32'(frz), 32'(fe[i]));
    end
    @(posedge i_clk);
    st <= lowpower_wait_state;
    rxdis <= 1'b1;
    wr(a_sp, 32'h0);
    settle();
    check(32'(frz), 32'h0);
    check(32'(rmii), 32'h0);
  endtask

  // refresh freeze lasts 176 us or 192 us: 0xDC0 or 0xF00 cycles at 50 ns
  task automatic s_refresh;
    int n;
    for (int b = 0; b < 3; b++) begin
      wr(a_sp, b == 1 ? 32'h0180 : 32'h0080);
      @(posedge i_clk);
      rstart <= 1'b1;
      @(posedge i_clk);
      rstart <= 1'b0;
      n = 0;
      if (b == 2) wr(a_sp, 32'h0);
      repeat (4200) begin
        @(negedge i_clk);
        if (frz.refresh_count === 1'b1) n++;
      end
      if (b < 2) check(32'(n), b == 1 ? 32'h0F00 : 32'h0DC0);
      else check(32'(n < 10), 32'h1);
    end
  endtask

  // line-driver code per symbol, at reset values and after new codes
  task automatic s_level;
    tx_symbol_t sy [3] = '{sym_minus_one, sym_zero, sym_plus_one};
    logic [5:0] c0 [3] = '{6'h30, 6'h00, 6'h20};
    logic [5:0] c1 [3] = '{6'h15, 6'h2A, 6'h3F};
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        wr(a_la, 32'hFFFF_F56A);
        wr(a_lb, 32'hFFFF_FFFF);
        rdc(a_la, 32'h056A);
        rdc(a_lb, 32'h003F);
      end
      for (int i = 0; i < 3; i++) begin
        @(posedge i_clk);
        sym <= sy[i];
        settle();
        check(32'(code), 32'(p == 1 ? c1[i] : c0[i]));
      end
    end
  endtask

  // stage timer and per-stage equalizer holds, reset and rewritten
  task automatic s_eq;
    eq_stage_t sg [4] = '{stage_none, stage_ffe1, stage_ffe2, stage_ffe3};
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        wr(a_eq, 32'hFFFF_F580);
        rdc(a_eq, 32'h0580);
      end
      check(32'(tsel), p == 1 ? 32'h5 : 32'h4);
      for (int i = 0; i < 4; i++) begin
        @(posedge i_clk);
        stg <= sg[i];
        settle();
        check(32'(frz.ffe_stage), 32'((p == 1 ? 4'h2 : 4'hC) >> i) & 32'h1);
      end
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    i_reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {aux25, gpio2, master, ref50, ind3, wake, mint, rxdis, pend, rstart} = '0;
    st = seq_other;
    sym = sym_zero;
    stg = stage_none;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    s_reset();
    s_io();
    s_shared();
    s_spare();
    s_refresh();
    s_level();
    s_eq();
    wrap_up();
  end
endmodule

`default_nettype wire
